/* chad_pkg.sv */
// package: register map, field layouts and types for the channel adapter buffers
package chad_pkg;

  // ****************************************************************
  // register indexes (i/o codes); the bus byte address is index * 4
  // ****************************************************************
  localparam logic [7:0] IDX_ISEL_CTRL = 8'h60;
  localparam logic [7:0] IDX_ADDR_CMD = 8'h61;
  localparam logic [7:0] IDX_DS_CTRL = 8'h62;
  localparam logic [7:0] IDX_LS_ADDR_STAT = 8'h63;
  localparam logic [7:0] IDX_LS_DATA01 = 8'h64;
  localparam logic [7:0] IDX_LS_DATA23 = 8'h65;
  localparam logic [7:0] IDX_NATIVE_STAT = 8'h66;
  localparam logic [7:0] IDX_ERR_COND = 8'h67;
  localparam logic [7:0] IDX_MODE = 8'h6c;
  localparam logic [7:0] IDX_EB_DATA = 8'h6d;
  localparam logic [7:0] IDX_CS_ADDR = 8'h6e;
  localparam logic [7:0] IDX_COUNT = 8'h6f;

  // ****************************************************************
  // field positions and sizes
  // ****************************************************************
  localparam int MODE_EB_BIT = 15;          // bit 0.0 of the halfword
  localparam int MODE_CS_BIT = 14;          // bit 0.1 of the halfword
  localparam int DS_FLAG_ESC_PEND = 0;      // program flags an esc status
  localparam int DS_FLAG_TIO_AVAIL = 1;     // test-i/o status available
  localparam int DS_FLAG_NATIVE_PEND = 2;   // native status not yet taken
  localparam int ERR_CS_OUT = 0;
  localparam int ERR_CS_IN = 1;
  localparam int ERR_CS_ADDR = 2;
  localparam int ERR_CS_EXC = 3;
  localparam int EB_DEPTH = 32;
  localparam int EB_PTR_W = 5;
  localparam int EB_CNT_MAX = 32;
  localparam int CS_CNT_MAX = 256;
  localparam logic [7:0] ISEL_EVT_SEL = 8'h80;  // initial selection event

  // ****************************************************************
  // reset values
  // ****************************************************************
  localparam logic [15:0] RST_HALF = 16'h0000;
  localparam logic [7:0] RST_BYTE = 8'h00;

  // channel-side initial selection event
  typedef struct packed {
    logic valid;
    logic [7:0] dev_addr;
    logic [7:0] cmd;
    logic emulation;     // address belongs to the emulation subchannel
  } isel_evt_t;

  // cycle-steal error reports from the central control unit
  typedef struct packed {
    logic data_even;     // storage data arrived with even parity
    logic bad_data;      // unit saw even parity from us
    logic addr_even;     // address bus parity bad
    logic addr_prot;     // address in protected storage
  } cs_err_in_t;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_WRESP = 2'b01,
    ST_RDATA = 2'b10
  } bus_state_t;

endpackage

/* channel_adapter_buffers.sv */
// channel adapter buffers: data-flow register set behind an axi4-lite slave
// Function
// (R1) capture device address and command at selection; read at 0x61
// (R2) four local data bytes: bytes 1-2 at 0x64, bytes 3-4 at 0x65
// (R3) local store keeps device address and emulation status at 0x63
// (R4) native status byte at 0x66, driven out on native status transfers
// (R5) native selection before status taken presents stored native status
// (R6) emulation selection with both flags presents program emulation status
// (R7) selection event recorded in control register read at 0x60
// (R8) data/status control register read and written at 0x62
// (R9) error/condition latches read at 0x67; errors raise error interrupt
// (R10) extended mode buffers 32 bytes; input 0x6c preloads in register
// (R11) input 0x6d returns in register then refills from next pair
// (R12) output 0x6d writes two bytes into the extended buffer
// (R13) outbus even byte goes first, odd byte to next address
// (R14) extended mode byte count held, at most 32
// (R15) cycle-steal address is 18 bits: 2-bit extension plus 16-bit low
// (R16) the unit advances the cycle-steal address after each transfer; here it changes only on register writes
// (R17) cycle-steal byte count held, at most 256
// (R18) storage data with even parity sets outbound-data error; here only in cycle-steal mode
// (R19) unit's bad-data report sets inbound-data error
// (R20) unit's address parity report sets address-bus error
// (R21) unit's protected-address report sets address-exception
// (R22) any cycle-steal error requests a level 1 interrupt
// (R23) both mode bits set selects extended-buffer mode
// (R24) in cycle-steal mode buffer locations 0 and 1 are the data buffer
//
// Local design decisions: the address map and register access over AXI4-Lite.
`timescale 1ns/1ps
module channel_adapter_buffers (
  input wire logic aclk,                      // 20 mhz clock
  input wire logic aresetn,                   // synchronous reset, low
  input wire logic [9:0] s_axi_awaddr,        // write address
  input wire logic s_axi_awvalid,             // write address valid
  output logic s_axi_awready,                 // write address ready
  input wire logic [31:0] s_axi_wdata,        // write data
  input wire logic [3:0] s_axi_wstrb,         // write strobes
  input wire logic s_axi_wvalid,              // write data valid
  output logic s_axi_wready,                  // write data ready
  output logic [1:0] s_axi_bresp,             // write response
  output logic s_axi_bvalid,                  // write response valid
  input wire logic s_axi_bready,              // write response ready
  input wire logic [9:0] s_axi_araddr,        // read address
  input wire logic s_axi_arvalid,             // read address valid
  output logic s_axi_arready,                 // read address ready
  output logic [31:0] s_axi_rdata,            // read data
  output logic [1:0] s_axi_rresp,             // read response
  output logic s_axi_rvalid,                  // read data valid
  input wire logic s_axi_rready,              // read data ready
  input wire chad_pkg::isel_evt_t isel,       // channel initial selection
  input wire logic native_status_taken,       // channel accepted native stat
  input wire logic native_status_xfer,        // native status transfer phase
  input wire chad_pkg::cs_err_in_t cs_err,    // cycle-steal error reports
  input wire logic [3:0] async_cond,          // asynchronous conditions
  output logic [7:0] chan_status,             // status byte to channel
  output logic extended_buffer_mode,          // extended mode active
  output logic cycle_steal_mode,              // cycle-steal mode active
  output logic [17:0] cycle_steal_address,    // storage address
  output logic [15:0] cs_buffer,              // last pair written at 0x6d; locations 0 and 1 in cycle-steal mode
  output logic l1_irq,                        // level 1 request
  output logic err_irq                        // error interrupt
);

  // ****************************************************************
  // state
  // ****************************************************************
  typedef struct packed {
    chad_pkg::bus_state_t bst;
    logic awready;
    logic wready;
    logic arready;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [1:0] rresp;
    logic [31:0] rdata;
    logic have_aw;
    logic have_w;
    logic [7:0] waddr;
    logic [15:0] wdata;
    logic [7:0] isel_ctrl;
    logic [7:0] sel_addr;
    logic [7:0] sel_cmd;
    logic [7:0] ds_ctrl;
    logic [7:0] ls_addr;
    logic [7:0] ls_esc_stat;
    logic [31:0] ls_data;
    logic [7:0] native_stat;
    logic [3:0] cs_errs;
    logic [3:0] async_lat;
    logic eb_mode;
    logic cs_mode;
    logic [4:0] eb_ptr;
    logic [15:0] in_reg;
    logic [15:0] outbus;
    logic [5:0] eb_count;
    logic [8:0] cs_count;
    logic [1:0] cs_ext;
    logic [15:0] cs_low;
    logic [7:0] chan_status;
    logic l1_irq;
    logic err_irq;
  } state_t;

  state_t q, d;
  logic [7:0] eb_mem [0:chad_pkg::EB_DEPTH-1];
  logic eb_we;
  logic [4:0] eb_wptr;
  logic [15:0] eb_wval;

  // decode a bus byte address into its register code
  function automatic logic [7:0] reg_code(input logic [9:0] a);
    reg_code = a[9:2];
  endfunction

  // read a byte pair from the extended buffer, even byte high
  function automatic logic [15:0] eb_pair(input logic [4:0] p);
    eb_pair = {eb_mem[{p[4:1], 1'b0}], eb_mem[{p[4:1], 1'b1}]};
  endfunction

  // ****************************************************************
  // next-state logic
  // ****************************************************************
  always_comb begin
    logic [7:0] rc;
    logic [31:0] rv;
    logic rok;
    logic wok;
    rc = 8'h00;
    rv = 32'h0000_0000;
    rok = 1'b0;
    wok = 1'b0;
    d = q;
    eb_we = 1'b0;
    eb_wptr = q.eb_ptr;
    eb_wval = q.outbus;
    d.awready = 1'b0;
    d.wready = 1'b0;
    d.arready = 1'b0;

    // initial selection capture; the event bit sticks until written   (R1)
    if (isel.valid) begin
      d.sel_addr = isel.dev_addr; // R1
      d.sel_cmd = isel.cmd; // R1
      d.isel_ctrl = q.isel_ctrl | chad_pkg::ISEL_EVT_SEL; // R7
      // status presented: program status overrides hardware status
      if (!isel.emulation && q.ds_ctrl[chad_pkg::DS_FLAG_NATIVE_PEND]) begin
        d.chan_status = q.native_stat; // R5
      end else if (isel.emulation &&
                   q.ds_ctrl[chad_pkg::DS_FLAG_ESC_PEND] &&
                   q.ds_ctrl[chad_pkg::DS_FLAG_TIO_AVAIL]) begin
        d.chan_status = q.ls_esc_stat; // R6
      end else begin
        d.chan_status = chad_pkg::RST_BYTE;
      end
    end else if (native_status_xfer) begin
      d.chan_status = q.native_stat; // R4
    end
    if (native_status_taken) begin
      d.ds_ctrl[chad_pkg::DS_FLAG_NATIVE_PEND] = 1'b0;
    end

    // error latches: set wins over any software clear
    d.cs_errs[chad_pkg::ERR_CS_OUT] = q.cs_errs[chad_pkg::ERR_CS_OUT] |
      (cs_err.data_even & q.cs_mode); // R18
    d.cs_errs[chad_pkg::ERR_CS_IN] = q.cs_errs[chad_pkg::ERR_CS_IN] |
      cs_err.bad_data; // R19
    d.cs_errs[chad_pkg::ERR_CS_ADDR] = q.cs_errs[chad_pkg::ERR_CS_ADDR] |
      cs_err.addr_even; // R20
    d.cs_errs[chad_pkg::ERR_CS_EXC] = q.cs_errs[chad_pkg::ERR_CS_EXC] |
      cs_err.addr_prot; // R21
    d.async_lat = q.async_lat | async_cond; // R9

    // write channel: take address and data in either order
    if (s_axi_awvalid && !q.have_aw && !q.awready &&
        q.bst == chad_pkg::ST_IDLE) begin
      d.awready = 1'b1;
      d.have_aw = 1'b1;
      d.waddr = reg_code(s_axi_awaddr);
    end
    if (s_axi_wvalid && !q.have_w && !q.wready &&
        q.bst == chad_pkg::ST_IDLE) begin
      d.wready = 1'b1;
      d.have_w = 1'b1;
      d.wdata = s_axi_wdata[15:0];
    end

    case (q.bst)
      chad_pkg::ST_IDLE: begin
        if (q.have_aw && q.have_w) begin
          d.have_aw = 1'b0;
          d.have_w = 1'b0;
          d.bst = chad_pkg::ST_WRESP;
          d.bvalid = 1'b1;
          wok = 1'b1;
          case (q.waddr)
            chad_pkg::IDX_ISEL_CTRL: begin
              d.isel_ctrl = isel.valid ? chad_pkg::ISEL_EVT_SEL
                                       : chad_pkg::RST_BYTE;
            end
            chad_pkg::IDX_ADDR_CMD: ;
            chad_pkg::IDX_DS_CTRL: d.ds_ctrl = q.wdata[7:0]; // R8
            chad_pkg::IDX_LS_ADDR_STAT: begin
              d.ls_addr = q.wdata[15:8]; // R3
              d.ls_esc_stat = q.wdata[7:0]; // R3
            end
            chad_pkg::IDX_LS_DATA01: d.ls_data[31:16] = q.wdata; // R2
            chad_pkg::IDX_LS_DATA23: d.ls_data[15:0] = q.wdata; // R2
            chad_pkg::IDX_NATIVE_STAT: begin
              d.native_stat = q.wdata[7:0]; // R4
              d.ds_ctrl[chad_pkg::DS_FLAG_NATIVE_PEND] = 1'b1;
            end
            chad_pkg::IDX_ERR_COND: begin
              // write-one-to-clear, but new events keep their bit
              d.cs_errs = d.cs_errs & ~(q.wdata[3:0] & ~{cs_err.addr_prot,
                cs_err.addr_even, cs_err.bad_data,
                cs_err.data_even & q.cs_mode});
              d.async_lat = d.async_lat & ~(q.wdata[7:4] & ~async_cond);
            end
            chad_pkg::IDX_MODE: begin
              d.eb_mode = q.wdata[chad_pkg::MODE_EB_BIT]; // R23
              d.cs_mode = q.wdata[chad_pkg::MODE_CS_BIT] &
                          ~q.wdata[chad_pkg::MODE_EB_BIT]; // R23
            end
            chad_pkg::IDX_EB_DATA: begin
              // even byte at the pointer, odd byte at the next address
              d.outbus = q.wdata;
              eb_we = 1'b1; // R12
              eb_wptr = q.cs_mode ? 5'd0 : q.eb_ptr; // R24
              eb_wval = q.wdata; // R13
              if (!q.cs_mode) begin
                d.eb_ptr = q.eb_ptr + 5'd2; // R12
              end
            end
            chad_pkg::IDX_CS_ADDR: begin
              d.cs_low = q.wdata; // R15
            end
            chad_pkg::IDX_COUNT: begin
              // the extended count is clipped to its documented maximum; a cycle-steal count field of 0 stands for 256
              if (q.wdata[5:0] > 6'(chad_pkg::EB_CNT_MAX)) begin
                d.eb_count = 6'(chad_pkg::EB_CNT_MAX); // R14
              end else begin
                d.eb_count = q.wdata[5:0]; // R14
              end
              d.cs_ext = q.wdata[15:14]; // R15
              d.cs_count = (q.wdata[13:6] == 8'h00) ?
                9'(chad_pkg::CS_CNT_MAX) : {1'b0, q.wdata[13:6]}; // R17
            end
            default: wok = 1'b0;
          endcase
          d.bresp = wok ? 2'b00 : 2'b10;
        end else if (s_axi_arvalid && !q.arready) begin
          d.arready = 1'b1;
          d.bst = chad_pkg::ST_RDATA;
          d.rvalid = 1'b1;
          rc = reg_code(s_axi_araddr);
          rok = 1'b1;
          case (rc)
            chad_pkg::IDX_ISEL_CTRL: rv = {24'h0, q.isel_ctrl}; // R7
            chad_pkg::IDX_ADDR_CMD: rv = {16'h0, q.sel_addr, q.sel_cmd}; // R1
            chad_pkg::IDX_DS_CTRL: rv = {24'h0, q.ds_ctrl}; // R8
            chad_pkg::IDX_LS_ADDR_STAT: rv = {16'h0, q.ls_addr,
                                              q.ls_esc_stat}; // R3
            chad_pkg::IDX_LS_DATA01: rv = {16'h0, q.ls_data[31:16]}; // R2
            chad_pkg::IDX_LS_DATA23: rv = {16'h0, q.ls_data[15:0]}; // R2
            chad_pkg::IDX_NATIVE_STAT: rv = {24'h0, q.native_stat}; // R4
            chad_pkg::IDX_ERR_COND: rv = {24'h0, q.async_lat,
                                          q.cs_errs}; // R9
            chad_pkg::IDX_MODE: begin
              // preload: pointer restarts and the first pair is loaded
              rv = {16'h0, q.eb_mode, q.cs_mode, 14'h0};
              d.eb_ptr = 5'd2; // R10
              d.in_reg = eb_pair(5'd0); // R10
            end
            chad_pkg::IDX_EB_DATA: begin
              rv = {16'h0, q.in_reg}; // R11
              d.in_reg = eb_pair(q.cs_mode ? 5'd0 : q.eb_ptr); // R11
              if (!q.cs_mode) begin
                d.eb_ptr = q.eb_ptr + 5'd2; // R11
              end
            end
            chad_pkg::IDX_CS_ADDR: rv = {14'h0, q.cs_ext, q.cs_low}; // R15
            chad_pkg::IDX_COUNT: rv = {7'h0, q.cs_count, 10'h0,
                                       q.eb_count}; // R17
            default: rok = 1'b0;
          endcase
          d.rdata = rv;
          d.rresp = rok ? 2'b00 : 2'b10;
        end
      end
      chad_pkg::ST_WRESP: begin
        if (s_axi_bready) begin
          d.bvalid = 1'b0;
          d.bst = chad_pkg::ST_IDLE;
        end
      end
      chad_pkg::ST_RDATA: begin
        if (s_axi_rready) begin
          d.rvalid = 1'b0;
          d.bst = chad_pkg::ST_IDLE;
        end
      end
      default: d.bst = chad_pkg::ST_IDLE;
    endcase

    d.l1_irq = |d.cs_errs; // R22
    d.err_irq = |d.cs_errs; // R9
  end

  // ****************************************************************
  // registers
  // ****************************************************************
  // buffer contents carry no reset: software must fill before use
  always_ff @(posedge aclk) begin
    if (eb_we) begin
      eb_mem[{eb_wptr[4:1], 1'b0}] <= eb_wval[15:8]; // R13
      eb_mem[{eb_wptr[4:1], 1'b1}] <= eb_wval[7:0]; // R13
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  // outputs come straight from flip-flops
  assign s_axi_awready = q.awready;
  assign s_axi_wready = q.wready;
  assign s_axi_arready = q.arready;
  assign s_axi_bvalid = q.bvalid;
  assign s_axi_bresp = q.bresp;
  assign s_axi_rvalid = q.rvalid;
  assign s_axi_rresp = q.rresp;
  assign s_axi_rdata = q.rdata;
  assign chan_status = q.chan_status;
  assign extended_buffer_mode = q.eb_mode;
  assign cycle_steal_mode = q.cs_mode;
  assign cycle_steal_address = {q.cs_ext, q.cs_low}; // R15
  assign cs_buffer = q.outbus; // R24
  assign l1_irq = q.l1_irq;
  assign err_irq = q.err_irq;

  // ****************************************************************
  // assertions
  // ****************************************************************
  property p_sel_capture; // R1
    @(posedge aclk) disable iff (!aresetn)
      isel.valid |=> (q.sel_addr == $past(isel.dev_addr)) &&
                     (q.sel_cmd == $past(isel.cmd));
  endproperty
  a_sel_capture: assert property (p_sel_capture) // R1
    else $error("selection address or command not captured");

  property p_isel_event; // R7
    @(posedge aclk) disable iff (!aresetn)
      isel.valid |=> q.isel_ctrl[7];
  endproperty
  a_isel_event: assert property (p_isel_event) // R7
    else $error("selection event not recorded");

  property p_native_present; // R5
    @(posedge aclk) disable iff (!aresetn)
      (isel.valid && !isel.emulation &&
       q.ds_ctrl[chad_pkg::DS_FLAG_NATIVE_PEND])
      |=> chan_status == $past(q.native_stat);
  endproperty
  a_native_present: assert property (p_native_present) // R5
    else $error("native status not presented");

  property p_esc_present; // R6
    @(posedge aclk) disable iff (!aresetn)
      (isel.valid && isel.emulation && q.ds_ctrl[0] && q.ds_ctrl[1])
      |=> chan_status == $past(q.ls_esc_stat);
  endproperty
  a_esc_present: assert property (p_esc_present) // R6
    else $error("emulation status not presented");

  property p_mode_excl; // R23
    @(posedge aclk) disable iff (!aresetn)
      !(q.eb_mode && q.cs_mode);
  endproperty
  a_mode_excl: assert property (p_mode_excl) // R23
    else $error("both modes active");

  property p_err_sticky; // R19
    @(posedge aclk) disable iff (!aresetn)
      cs_err.bad_data |=> q.cs_errs[chad_pkg::ERR_CS_IN] && l1_irq;
  endproperty
  a_err_sticky: assert property (p_err_sticky) // R19
    else $error("inbound error not latched or no level 1 request");

  // both requests follow the latches in the same cycle, so a software
  // clear drops them at once instead of one cycle late
  property p_l1_tracks; // R22
    @(posedge aclk) disable iff (!aresetn)
      (l1_irq == (|q.cs_errs)) && (err_irq == (|q.cs_errs));
  endproperty
  a_l1_tracks: assert property (p_l1_tracks) // R22
    else $error("level 1 request missing");

  property p_eb_count_max; // R14
    @(posedge aclk) disable iff (!aresetn)
      q.eb_count <= 6'(chad_pkg::EB_CNT_MAX);
  endproperty
  a_eb_count_max: assert property (p_eb_count_max) // R14
    else $error("extended byte count above maximum");

endmodule

/* chan_model.sv */
// far-side model: channel selection, status phase and unit error reports
`timescale 1ns/1ps
module chan_model (
  input wire logic aclk,             // adapter clock
  output chad_pkg::isel_evt_t isel,  // selection pulse
  output logic taken,                // native status accepted
  output logic xfer,                 // native status phase
  output chad_pkg::cs_err_in_t err,  // unit error reports
  output logic [3:0] cond            // asynchronous conditions
);
  // quiet at time zero
  initial begin
    isel = '0;
    taken = 1'h0;
    xfer = 1'h0;
    err = '0;
    cond = 4'h0;
  end
  // one selection; fields inverted after it so stale values never match
  task automatic sel(input logic [7:0] a, input logic [7:0] c,
      input logic e);
    @(posedge aclk);
    isel <= '{1'h1, a, c, e};
    @(posedge aclk);
    isel <= '{1'h0, ~a, ~c, ~e};
  endtask
  // one-cycle report pulses
  task automatic ev(input chad_pkg::cs_err_in_t e, input logic [3:0] q,
      input logic t);
    @(posedge aclk);
    err <= e;
    cond <= q;
    taken <= t;
    @(posedge aclk);
    err <= '0;
    cond <= 4'h0;
    taken <= 1'h0;
  endtask
  // native status phase is a level held by the channel
  task automatic phase(input logic v);
    @(posedge aclk);
    xfer <= v;
  endtask
endmodule

/* tb.sv */
// testbench: bus master, reference values and checks for the buffers
`timescale 1ns/1ps
module tb;
  logic aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready, taken, xfer, ebm, csm, l1, eirq;
  logic [9:0] awaddr, araddr;
  logic [31:0] wdata, rdata, rd, v;
  logic [1:0] bresp, rresp, rsp;
  logic [3:0] wstrb, cond;
  logic [7:0] stat, a8, c8, ns;
  logic [17:0] csa;
  logic [15:0] csbuf, lo;
  logic [5:0] eb;
  logic [8:0] csn;
  logic [7:0] mem [32];
  chad_pkg::isel_evt_t isel;
  chad_pkg::cs_err_in_t cs_err;
  int mismatches, tests_run, p;
  channel_adapter_buffers channel_adapter_buffers_i (.aclk(aclk),
    .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .isel(isel), .native_status_taken(taken), .native_status_xfer(xfer),
    .cs_err(cs_err), .async_cond(cond), .chan_status(stat),
    .extended_buffer_mode(ebm), .cycle_steal_mode(csm),
    .cycle_steal_address(csa), .cs_buffer(csbuf), .l1_irq(l1),
    .err_irq(eirq));
  chan_model chan_model_i (.aclk(aclk), .isel(isel), .taken(taken),
    .xfer(xfer), .err(cs_err), .cond(cond));
  // 20 mhz clock
  initial begin
    aclk = 1'h0;
    forever #25 aclk = ~aclk;
  end
  task automatic chk(input string n, input logic [31:0] e,
      input logic [31:0] g);
    tests_run++;
    if (g !== e) begin
      mismatches++;
      $display("MISMATCH %s expected %h seen %h", n, e, g);
    end
  endtask
  // write: address and data offered together, each dropped when taken
  task automatic wr(input logic [9:0] a, input logic [31:0] d);
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'h1;
    wvalid <= 1'h1;
    bready <= 1'h1;
    fork
      begin
        do @(posedge aclk); while (awready !== 1'h1);
        awvalid <= 1'h0;
        awaddr <= ~a;
      end
      begin
        do @(posedge aclk); while (wready !== 1'h1);
        wvalid <= 1'h0;
        wdata <= ~d;
      end
    join
    while (bvalid !== 1'h1) @(posedge aclk);
    rsp = bresp;
    bready <= 1'h0;
  endtask
  task automatic rdr(input logic [9:0] a);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'h1;
    rready <= 1'h1;
    do @(posedge aclk); while (arready !== 1'h1);
    arvalid <= 1'h0;
    araddr <= ~a;
    while (rvalid !== 1'h1) @(posedge aclk);
    rd = rdata;
    rsp = rresp;
    rready <= 1'h0;
  endtask
  task automatic rc(input logic [9:0] a, input logic [31:0] e, string n);
    rdr(a);
    chk(n, e, rd);
  endtask
  task automatic final_report();
    $display("checks %0d mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  // watchdog: the sequence needs well under a tenth of this span
  initial begin
    #2000000;
    mismatches++;
    final_report();
  end
  // ****************************************************************
  // main sequence
  // ****************************************************************
  initial begin
    aresetn = 1'h0;
    {awaddr, araddr, wdata} = '0;
    {awvalid, wvalid, bready, arvalid, rready} = '0;
    wstrb = 4'hf;
    rd = $urandom(75);
    repeat (16) @(posedge aclk);
    aresetn <= 1'h1;
    @(negedge aclk);
    chk("modes", 32'h0, {28'h0, ebm, csm, l1, eirq});
    a8 = $urandom;
    c8 = $urandom;
    chan_model_i.sel(a8, c8, 1'h0);
    rc(10'h184, {16'h0, a8, c8}, "addr_cmd");
    rc(10'h180, {24'h0, chad_pkg::ISEL_EVT_SEL}, "isel_ctrl");
    wr(10'h180, 32'h0);
    rc(10'h180, 32'h0, "isel_clr");
    for (int i = 0; i < 3; i++) begin
      v = $urandom;
      wr(10'h18c + 10'(4 * i), {16'h0, v[15:0]});
      rc(10'h18c + 10'(4 * i), {16'h0, v[15:0]}, "local");
    end
    // stored native status wins at selection and in status phase
    ns = $urandom;
    wr(10'h198, {24'h0, ns});
    rc(10'h198, {24'h0, ns}, "native");
    rc(10'h188, 32'h4, "ds_pend");
    chan_model_i.sel(a8, c8, 1'h0);
    @(negedge aclk);
    chk("sel_native", {24'h0, ns}, {24'h0, stat});
    chan_model_i.phase(1'h1);
    repeat (2) @(negedge aclk);
    chk("xfer_stat", {24'h0, ns}, {24'h0, stat});
    chan_model_i.phase(1'h0);
    chan_model_i.ev('0, 4'ha, 1'h1);
    rc(10'h188, 32'h0, "ds_taken");
    // emulation status presented when both flags are up
    v = $urandom;
    wr(10'h18c, {16'h0, v[15:0]});
    wr(10'h188, 32'h3);
    rc(10'h188, 32'h3, "ds_flags");
    chan_model_i.sel(v[15:8], c8, 1'h1);
    @(negedge aclk);
    chk("sel_emu", {24'h0, v[7:0]}, {24'h0, stat});
    // status phase replaces the emulation byte with the native one
    chan_model_i.phase(1'h1);
    repeat (2) @(negedge aclk);
    chk("xfer_after_emu", {24'h0, ns}, {24'h0, stat});
    chan_model_i.phase(1'h0);
    // each cycle-steal error latch, interrupts, then clear
    wr(10'h1b0, 32'h4000);
    for (int i = 0; i < 4; i++) begin
      chan_model_i.ev(chad_pkg::cs_err_in_t'(4'h8 >> i), 4'h0, 1'h0);
      rc(10'h19c, {24'h0, 4'ha, 4'h1 << i}, "err");
      chk("l1", 32'h1, {31'h0, l1});
      chk("eirq", 32'h1, {31'h0, eirq});
      wr(10'h19c, 32'hf);
    end
    rc(10'h19c, 32'ha0, "err_clr");
    chk("l1_off", 32'h0, {30'h0, l1, eirq});
    // counts and cycle-steal address, then software rewrites it one halfword on
    wr(10'h1bc, 32'hc03f);
    rc(10'h1bc, 32'h0100_0020, "cnt_max");
    v = $urandom;
    eb = (v[5:0] > 6'h20) ? 6'h20 : v[5:0];
    csn = (v[13:6] == 8'h0) ? 9'h100 : {1'h0, v[13:6]};
    wr(10'h1bc, {16'h0, v[15:0]});
    rc(10'h1bc, {7'h0, csn, 10'h0, eb}, "cnt");
    lo = $urandom;
    wr(10'h1b8, {16'h0, lo});
    chk("csa", {14'h0, v[15:14], lo}, {14'h0, csa});
    wr(10'h1b8, {16'h0, lo + 16'h2});
    chk("csa_next", {14'h0, v[15:14], lo + 16'h2}, {14'h0, csa});
    // both mode bits: extended wins; fill 16 pairs then drain them
    wr(10'h1b0, 32'hc000);
    chk("mode", 32'h2, {30'h0, ebm, csm});
    rdr(10'h1b0);
    for (int i = 0; i < 16; i++) begin
      v = $urandom;
      p = (2 + 2 * i) % 32;
      mem[p] = v[15:8];
      mem[p + 1] = v[7:0];
      wr(10'h1b4, {16'h0, v[15:0]});
    end
    rdr(10'h1b0);
    for (int i = 0; i < 16; i++) begin
      rdr(10'h1b4);
      chk("eb_data", {16'h0, mem[2 * i], mem[2 * i + 1]}, rd);
    end
    chan_model_i.ev(chad_pkg::cs_err_in_t'(4'h8), 4'h0, 1'h0);
    rc(10'h19c, 32'ha0, "no_cs_err");
    // cycle-steal mode uses locations 0 and 1
    wr(10'h1b0, 32'h4000);
    v = $urandom;
    wr(10'h1b4, {16'h0, v[15:0]});
    chk("cs_buf", {16'h0, v[15:0]}, {16'h0, csbuf});
    chk("mode_cs", 32'h1, {30'h0, ebm, csm});
    // unmapped place refuses both ways
    wr(10'h1a0, 32'h1234);
    chk("wr_err", 32'h2, {30'h0, rsp});
    rdr(10'h1a0);
    chk("rd_err", 32'h2, {30'h0, rsp});
    final_report();
  end
endmodule
